// *** core/pdl_map.vh ***
/*
  Constants for the program/debug link control block: register offsets,
  field positions, reset values, codes and timing figures.
  Assumes it is included by bare name by the design files.
*/
`ifndef PDL_MAP_VH
`define PDL_MAP_VH

// clock and times
`define PDL_CLK_MHZ        25
`define PDL_SYNC_TMO_US    13500
`define PDL_SYNC_TMO_CYC   19'd337500
`define PDL_LSO_PROT_CYC   10'd768
`define PDL_CLK_RDY_CYC    19'd16
`define PDL_ACC_TMO_CYC    19'd2048

// serial frame
`define PDL_SMP_LAST       4'd15
`define PDL_VOTE_A         4'd7
`define PDL_VOTE_B         4'd8
`define PDL_VOTE_C         4'd9
`define PDL_BIT_PAR        4'd9
`define PDL_BIT_STOP1      4'd10
`define PDL_BIT_STOP2      4'd11
`define PDL_BRK_SMP        8'd192
`define PDL_SYNC_BYTE      8'h55
`define PDL_SYNC_FALL_LAST 3'h4
`define PDL_SYNC_SHIFT     7
`define PDL_MIN_DIV        13'h0002
`define PDL_DEF_DIV        13'h0020
`define PDL_GUARD_UNIT     12'h010
`define PDL_GT_NONE        3'h7

// register offsets
`define PDL_REG_STATUS_A   4'h0
`define PDL_REG_STATUS_B   4'h1
`define PDL_REG_CTRL_A     4'h2
`define PDL_REG_CTRL_B     4'h3
`define PDL_REG_ACC_CLK    4'h9

// fields and reset values
`define PDL_CTRLA_PARD     7
`define PDL_CTRLB_DIS      2
`define PDL_CTRLA_RST      8'h00
`define PDL_CLKSEL_RST     2'h3
`define PDL_CLKSEL_16M     2'h1
`define PDL_CLKSEL_8M      2'h2

// instruction codes
`define PDL_OP_LDS         3'h0
`define PDL_OP_LD          3'h1
`define PDL_OP_STS         3'h2
`define PDL_OP_ST          3'h3
`define PDL_OP_CONTROL_STATUS_LOAD        3'h4
`define PDL_OP_REPEAT      3'h5
`define PDL_OP_CONTROL_STATUS_STORE        3'h6
`define PDL_OP_KEY         3'h7
`define PDL_SZ_BYTE        2'h0
`define PDL_SZ_WORD        2'h1
`define PDL_KEY_SZ_128     2'h1

// error signatures
`define PDL_ERR_NONE       3'h0
`define PDL_ERR_PAR        3'h1
`define PDL_ERR_FRM        3'h2
`define PDL_ERR_ACC        3'h3
`define PDL_ERR_START      3'h4
`define PDL_ERR_CONT       3'h5

// reset pin configuration fuse
`define PDL_RSTCFG_GPIO    2'h0
`define PDL_RSTCFG_DBG     2'h1

`endif

// *** core/pdl_kmem.v ***
/*
  Key byte store: 16 x 8 bits, one write port, registered read port.
  Assumes one clock, a clock enable and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module pdl_kmem (
  input  wire       clock_i,   // clock
  input  wire       reset_i,   // async reset, high
  input  wire       ce_i,      // clock enable
  input  wire       wr_i,      // write strobe
  input  wire [3:0] waddr_i,   // write address
  input  wire [7:0] wdata_i,   // write data
  input  wire [3:0] raddr_i,   // read address
  output wire [7:0] rdata_o    // registered read data
);
  reg [7:0] mem [0:15];
  reg [7:0] rdata_ff;

  always @(posedge clock_i) begin
    if (ce_i && wr_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_ff <= 8'h00;
    end else if (ce_i) begin
      rdata_ff <= mem[raddr_i];
    end
  end

  assign rdata_o = rdata_ff;
endmodule // pdl_kmem

// *** core/pdl_ctrl.v ***
/*
  Single-wire program/debug link control: high-voltage enable, disable,
  auto-disable, gpio driver protection, baud recovery, frame receive and
  transmit, break, error signature, guard time and instruction decode.
  Assumes reset_i is the power-on reset, pins arrive asynchronously and
  the system side answers forwarded instructions on bus_req_o/bus_ack_i.
*/
`timescale 1ns/1ps
`include "pdl_map.vh"

// How it works
// - high-voltage pulse makes reset pin debug
// - pulse rising edge resets the interface
// - interface held in reset until pin low
// - only power-on reset undoes high-voltage enable
// - disable bit resets interface, keys, clock request
// - disable keeps high-voltage pin assignment
// - no sync within 13.5 ms disables
// - bad first sync length disables
// - gpio driver off 768 slow cycles
// - detect errors, report in error signature
// - error state ignores all but break, disable, high-voltage pulse
// - break restores default interface clock select
// - reading status returns then clears signature
// - guard idle bits before every response
// - guard value alone sets idle time
// - one byte instruction after each sync
// - three bit opcode selects instruction
// - size fields: byte, word, rest reserved
// - start, eight data, even parity, two stops
// - break is twelve low bit periods
// - sync byte 0x55 sets baud rate
// - sixteen samples, vote on 7, 8, 9
module pdl_ctrl #(
  parameter [18:0] SYNC_TMO_CYC = `PDL_SYNC_TMO_CYC
) (
  input  wire       clock_i,            // 25 MHz clock
  input  wire       reset_i,            // power-on reset, async, high
  input  wire       ce_i,               // clock enable
  input  wire       sys_reset_i,        // system reset pulse
  input  wire [1:0] reset_pin_config_i, // reset pin config fuse field
  input  wire       hv_pulse_i,         // high-voltage detector on pin
  input  wire       lso_clk_i,          // low-speed oscillator clock
  input  wire       pin_i,              // link pin input
  output wire       pin_o,              // link pin output value
  output wire       pin_oe_o,           // link pin output enable
  output wire       pin_is_debug_o,     // reset pin used by debug link
  output wire       gpio_drive_allow_o, // gpio output driver allowed
  output wire       clk_req_o,          // interface oscillator request
  input  wire [3:0] reg_addr_i,         // register address
  input  wire [7:0] reg_wdata_i,        // register write data
  input  wire       reg_wr_i,           // register write strobe
  input  wire       reg_rd_i,           // register read strobe
  output wire [7:0] reg_rdata_o,        // read data, cycle after strobe
  output wire       bus_req_o,          // forwarded instruction pending
  input  wire       bus_ack_i,          // system accepted instruction
  output wire [7:0] ins_byte_o,         // last instruction byte
  output wire [2:0] ins_opcode_o,       // instruction opcode
  output wire [1:0] ins_addr_bytes_o,   // address bytes, 0 reserved
  output wire [1:0] ins_data_bytes_o,   // data bytes, 0 reserved
  output wire       key_valid_o,        // key bytes received
  input  wire [3:0] key_addr_i,         // key byte read address
  output wire [7:0] key_data_o          // key byte, registered
);
  localparam [3:0] S_OFF = 4'd0, S_HOLD = 4'd1, S_DRIVE = 4'd2,
                   S_WSYNC = 4'd3, S_SYNC = 4'd4, S_SYNCEND = 4'd5,
                   S_RXINS = 4'd6, S_RXDAT = 4'd7, S_RXKEY = 4'd8,
                   S_BUS = 4'd9, S_GUARD = 4'd10, S_TX = 4'd11,
                   S_ERR = 4'd12;

  reg  [2:0]  in_m_ff, in_s_ff, in_d_ff;
  reg  [1:0]  pre_ff;
  reg  [12:0] smp_cnt_ff, baud_div_ff;
  reg  [7:0]  brk_cnt_ff;
  reg         hv_lat_ff;
  reg  [9:0]  prot_cnt_ff;
  reg  [3:0]  state_ff;
  reg         first_ff;
  reg  [18:0] tmo_ff;
  reg  [19:0] meas_ff;
  reg  [2:0]  edge_ff;
  reg  [7:0]  ins_ff, tx_byte_ff, ctrl_a_ff, rdata_ff;
  reg  [4:0]  key_idx_ff, key_len_ff;
  reg  [11:0] guard_ff;
  reg  [1:0]  clk_sel_ff;
  reg  [2:0]  err_sig_ff;
  reg         key_valid_ff;
  reg         eng_on_ff, eng_tx_ff, eng_done_ff, v7_ff, v8_ff;
  reg  [2:0]  eng_err_ff;
  reg  [3:0]  smp_ff, bit_ff;
  reg  [11:0] tx_sh_ff;
  reg  [8:0]  rx_sh_ff;

  wire pin_s    = in_s_ff[0];
  wire pin_fall = in_d_ff[0] & ~in_s_ff[0];
  wire hv_rise  = in_s_ff[1] & ~in_d_ff[1];
  wire lso_rise = in_s_ff[2] & ~in_d_ff[2];

  // frequency of the interface clock follows the clock select
  wire ifc_tick = (clk_sel_ff == `PDL_CLKSEL_16M) |
                  ((clk_sel_ff == `PDL_CLKSEL_8M) & pre_ff[0]) |
                  (pre_ff == 2'h3);
  wire smp_tick = ifc_tick & (smp_cnt_ff == baud_div_ff - 13'h0001);

  wire linked   = (state_ff >= S_WSYNC);
  wire [7:0] rx_data = rx_sh_ff[7:0];
  // sync length rounded to the nearest sample period
  wire [19:0] meas_rnd = meas_ff + (20'h00001 << (`PDL_SYNC_SHIFT - 1));
  wire rx_state = (state_ff == S_RXINS) | (state_ff == S_RXDAT) |
                  (state_ff == S_RXKEY);
  wire done_ok  = eng_done_ff & (eng_err_ff == `PDL_ERR_NONE);
  wire brk_evt  = linked & smp_tick & ~eng_tx_ff & ~pin_s &
                  (brk_cnt_ff == `PDL_BRK_SMP - 8'd1);
  wire cs_we_dis = reg_wr_i & (reg_addr_i == `PDL_REG_CTRL_B) &
                   reg_wdata_i[`PDL_CTRLB_DIS];
  wire control_status_store_we  = (state_ff == S_RXDAT) & done_ok;
  wire control_status_store_dis = control_status_store_we & (ins_ff[3:0] == `PDL_REG_CTRL_B) &
                  rx_data[`PDL_CTRLB_DIS];
  wire dis_evt  = cs_we_dis | control_status_store_dis;
  wire abort    = brk_evt | dis_evt | hv_rise;
  wire acc_tmo  = (state_ff == S_BUS) & ~bus_ack_i &
                  (tmo_ff == `PDL_ACC_TMO_CYC - 19'd1);
  wire eng_fail = eng_done_ff & (eng_err_ff != `PDL_ERR_NONE) &
                  (rx_state | (state_ff == S_TX));
  wire err_evt  = eng_fail | acc_tmo;
  wire [2:0] err_code = acc_tmo ? `PDL_ERR_ACC : eng_err_ff;
  wire ins_ok   = (state_ff == S_RXINS) & done_ok;
  wire control_status_load_clr = ins_ok & (rx_data[7:5] == `PDL_OP_CONTROL_STATUS_LOAD) &
                  (rx_data[3:0] == `PDL_REG_STATUS_B);
  wire tx_go    = (state_ff == S_GUARD) & (guard_ff == 12'h000) &
                  ~eng_on_ff;
  wire eng_start = ~eng_on_ff & ~abort &
                   (tx_go | (rx_state & pin_fall));
  wire key_we   = (state_ff == S_RXKEY) & done_ok;

  function [7:0] cs_read;
    input [3:0] a;
    begin
      case (a)
        `PDL_REG_STATUS_A: cs_read = {state_ff, key_valid_ff,
                                      hv_lat_ff, 2'b00};
        `PDL_REG_STATUS_B: cs_read = {5'h00, err_sig_ff};
        `PDL_REG_CTRL_A:   cs_read = ctrl_a_ff;
        `PDL_REG_ACC_CLK:  cs_read = {6'h00, clk_sel_ff};
        default:           cs_read = 8'h00;
      endcase
    end
  endfunction

  function [1:0] sz_bytes;
    input [1:0] c;
    begin
      case (c)
        `PDL_SZ_BYTE: sz_bytes = 2'd1;
        `PDL_SZ_WORD: sz_bytes = 2'd2;
        default:      sz_bytes = 2'd0;
      endcase
    end
  endfunction

  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      in_m_ff <= 3'b001;
      in_s_ff <= 3'b001;
      in_d_ff <= 3'b001;
      pre_ff <= 2'h0;
      smp_cnt_ff <= 13'h0000;
      brk_cnt_ff <= 8'h00;
    end else if (ce_i) begin
      in_m_ff <= {lso_clk_i, hv_pulse_i, pin_i};
      in_s_ff <= in_m_ff;
      in_d_ff <= in_s_ff;
      pre_ff <= pre_ff + 2'h1;
      if (eng_start | smp_tick)
        smp_cnt_ff <= 13'h0000;
      else if (ifc_tick)
        smp_cnt_ff <= smp_cnt_ff + 13'h0001;
      // twelve low bit periods make a break
      if (pin_s | ~linked | eng_tx_ff)
        brk_cnt_ff <= 8'h00;
      else if (smp_tick && brk_cnt_ff != `PDL_BRK_SMP)
        brk_cnt_ff <= brk_cnt_ff + 8'h01;
    end
  end

  // high-voltage enable held until power-on reset
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      hv_lat_ff <= 1'b0;
      prot_cnt_ff <= 10'h000;
    end else if (ce_i) begin
      if (hv_rise)
        hv_lat_ff <= 1'b1;
      if (sys_reset_i)
        prot_cnt_ff <= 10'h000;
      else if (lso_rise && prot_cnt_ff != `PDL_LSO_PROT_CYC)
        prot_cnt_ff <= prot_cnt_ff + 10'h001;
    end
  end

  // disable never touches the pin assignment
  assign pin_is_debug_o = hv_lat_ff |
                          (reset_pin_config_i == `PDL_RSTCFG_DBG);
  assign gpio_drive_allow_o = ~hv_lat_ff &
                              (reset_pin_config_i == `PDL_RSTCFG_GPIO) &
                              (prot_cnt_ff == `PDL_LSO_PROT_CYC);

  // serial bit engine, half duplex
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      eng_on_ff <= 1'b0;
      eng_tx_ff <= 1'b0;
      eng_done_ff <= 1'b0;
      eng_err_ff <= `PDL_ERR_NONE;
      smp_ff <= 4'h0;
      bit_ff <= 4'h0;
      v7_ff <= 1'b1;
      v8_ff <= 1'b1;
      tx_sh_ff <= 12'hFFF;
      rx_sh_ff <= 9'h000;
    end else if (ce_i) begin
      eng_done_ff <= 1'b0;
      if (abort) begin
        eng_on_ff <= 1'b0;
        eng_tx_ff <= 1'b0;
      end else if (eng_start) begin
        eng_on_ff <= 1'b1;
        eng_tx_ff <= tx_go;
        smp_ff <= 4'h0;
        bit_ff <= 4'h0;
        eng_err_ff <= `PDL_ERR_NONE;
        // start, data, even parity, two stops
        tx_sh_ff <= {2'b11, ^tx_byte_ff, tx_byte_ff, 1'b0};
      end else if (eng_on_ff && smp_tick) begin
        smp_ff <= smp_ff + 4'h1;
        if (smp_ff == `PDL_VOTE_A)
          v7_ff <= pin_s;
        if (smp_ff == `PDL_VOTE_B)
          v8_ff <= pin_s;
        if (smp_ff == `PDL_VOTE_C) begin
          if (eng_tx_ff) begin
            // contention: line differs from driven bit
            if (pin_s != tx_sh_ff[0]) begin
              eng_on_ff <= 1'b0;
              eng_tx_ff <= 1'b0;
              eng_done_ff <= 1'b1;
              eng_err_ff <= `PDL_ERR_CONT;
            end
          end else if (bit_ff == 4'h0) begin
            if ((v7_ff & v8_ff) | ((v7_ff | v8_ff) & pin_s)) begin
              eng_on_ff <= 1'b0;
              eng_done_ff <= 1'b1;
              eng_err_ff <= `PDL_ERR_START;
            end
          end else if (bit_ff <= `PDL_BIT_PAR) begin
            rx_sh_ff <= {(v7_ff & v8_ff) | ((v7_ff | v8_ff) & pin_s),
                         rx_sh_ff[8:1]};
          end else if (~((v7_ff & v8_ff) | ((v7_ff | v8_ff) & pin_s))) begin
            // stop bit low is a frame error
            eng_on_ff <= 1'b0;
            eng_done_ff <= 1'b1;
            eng_err_ff <= `PDL_ERR_FRM;
          end else if (bit_ff == `PDL_BIT_STOP2) begin
            eng_on_ff <= 1'b0;
            eng_done_ff <= 1'b1;
            if ((^rx_sh_ff) & ~ctrl_a_ff[`PDL_CTRLA_PARD])
              eng_err_ff <= `PDL_ERR_PAR;
          end
        end
        if (smp_ff == `PDL_SMP_LAST) begin
          bit_ff <= bit_ff + 4'h1;
          if (eng_tx_ff) begin
            tx_sh_ff <= {1'b1, tx_sh_ff[11:1]};
            if (bit_ff == `PDL_BIT_STOP2) begin
              eng_on_ff <= 1'b0;
              eng_tx_ff <= 1'b0;
              eng_done_ff <= 1'b1;
            end
          end
        end
      end
    end
  end

  // link control state machine
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff <= S_OFF;
      first_ff <= 1'b0;
      tmo_ff <= 19'h00000;
      meas_ff <= 20'h00000;
      edge_ff <= 3'h0;
      baud_div_ff <= `PDL_DEF_DIV;
      ins_ff <= 8'h00;
      tx_byte_ff <= 8'h00;
      key_idx_ff <= 5'h00;
      key_len_ff <= 5'h00;
      guard_ff <= 12'h000;
      key_valid_ff <= 1'b0;
    end else if (ce_i) begin
      tmo_ff <= tmo_ff + 19'd1;
      // rising edge of pulse resets the interface
      if (hv_rise) begin
        state_ff <= S_HOLD;
        key_valid_ff <= 1'b0;
      end else if (dis_evt) begin
        state_ff <= S_OFF;
        key_valid_ff <= 1'b0;
      // only a break, disable or high-voltage pulse leaves the error state
      end else if (brk_evt) begin
        state_ff <= S_WSYNC;
        first_ff <= 1'b0;
      end else if (err_evt) begin
        state_ff <= S_ERR;
      end else begin
        case (state_ff)
          S_OFF: begin
            if (pin_is_debug_o & pin_fall) begin
              state_ff <= S_DRIVE;
              tmo_ff <= 19'd0;
            end
          end
          // low level on pin releases the reset
          S_HOLD: begin
            if (~pin_s) begin
              state_ff <= S_DRIVE;
              tmo_ff <= 19'd0;
            end
          end
          S_DRIVE: begin
            if (tmo_ff == `PDL_CLK_RDY_CYC - 19'd1) begin
              state_ff <= S_WSYNC;
              first_ff <= 1'b1;
              tmo_ff <= 19'd0;
            end
          end
          S_WSYNC: begin
            if (pin_fall) begin
              state_ff <= S_SYNC;
              meas_ff <= 20'h00000;
              edge_ff <= 3'h0;
            end else if (first_ff && tmo_ff == SYNC_TMO_CYC - 19'd1) begin
              state_ff <= S_OFF;
            end
          end
          // eight bit periods between first and fifth fall
          S_SYNC: begin
            if (ifc_tick)
              meas_ff <= meas_ff + 20'h00001;
            if (pin_fall)
              edge_ff <= edge_ff + 3'h1;
            // sync too long or too short
            if (meas_ff == 20'hFFFFF) begin
              state_ff <= first_ff ? S_OFF : S_WSYNC;
            end else if (pin_fall &&
                         edge_ff == `PDL_SYNC_FALL_LAST - 3'h1) begin
              if (meas_rnd[19:`PDL_SYNC_SHIFT] < `PDL_MIN_DIV) begin
                state_ff <= first_ff ? S_OFF : S_WSYNC;
              end else begin
                baud_div_ff <= meas_rnd[19:`PDL_SYNC_SHIFT];
                state_ff <= S_SYNCEND;
              end
            end
          end
          S_SYNCEND: begin
            if (pin_s) begin
              state_ff <= S_RXINS;
              first_ff <= 1'b0;
            end
          end
          // one instruction byte, decoded by opcode
          S_RXINS: begin
            if (done_ok) begin
              ins_ff <= rx_data;
              tmo_ff <= 19'd0;
              case (rx_data[7:5])
                `PDL_OP_CONTROL_STATUS_STORE: state_ff <= S_RXDAT;
                `PDL_OP_CONTROL_STATUS_LOAD: begin
                  state_ff <= S_GUARD;
                  tx_byte_ff <= cs_read(rx_data[3:0]);
                  // guard idle bits from guard value only
                  guard_ff <= (ctrl_a_ff[2:0] == `PDL_GT_NONE) ? 12'h000 :
                              (`PDL_GUARD_UNIT << (3'h7 - ctrl_a_ff[2:0]));
                end
                `PDL_OP_KEY: begin
                  state_ff <= rx_data[2] ? S_BUS : S_RXKEY;
                  key_idx_ff <= 5'h00;
                  key_len_ff <= (rx_data[1:0] == `PDL_KEY_SZ_128) ?
                                5'd16 : 5'd8;
                end
                default: state_ff <= S_BUS;
              endcase
            end
          end
          S_RXDAT: begin
            if (done_ok)
              state_ff <= S_WSYNC;
          end
          S_RXKEY: begin
            if (done_ok) begin
              key_idx_ff <= key_idx_ff + 5'h01;
              if (key_idx_ff == key_len_ff - 5'h01) begin
                key_valid_ff <= 1'b1;
                state_ff <= S_WSYNC;
              end
            end
          end
          S_BUS: begin
            if (bus_ack_i)
              state_ff <= S_WSYNC;
          end
          S_GUARD: begin
            if (tx_go)
              state_ff <= S_TX;
            else if (smp_tick && guard_ff != 12'h000)
              guard_ff <= guard_ff - 12'h001;
          end
          S_TX: begin
            if (eng_done_ff)
              state_ff <= S_WSYNC;
          end
          S_ERR: state_ff <= S_ERR;
          default: state_ff <= S_OFF;
        endcase
      end
    end
  end

  // control and status registers, shared by port and link
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_a_ff <= `PDL_CTRLA_RST;
      clk_sel_ff <= `PDL_CLKSEL_RST;
      err_sig_ff <= `PDL_ERR_NONE;
      rdata_ff <= 8'h00;
    end else if (ce_i) begin
      rdata_ff <= reg_rd_i ? cs_read(reg_addr_i) : 8'h00;
      if (reg_wr_i && reg_addr_i == `PDL_REG_CTRL_A)
        ctrl_a_ff <= reg_wdata_i;
      else if (control_status_store_we && ins_ff[3:0] == `PDL_REG_CTRL_A)
        ctrl_a_ff <= rx_data;
      if (brk_evt)
        clk_sel_ff <= `PDL_CLKSEL_RST;
      else if (reg_wr_i && reg_addr_i == `PDL_REG_ACC_CLK)
        clk_sel_ff <= reg_wdata_i[1:0];
      else if (control_status_store_we && ins_ff[3:0] == `PDL_REG_ACC_CLK)
        clk_sel_ff <= rx_data[1:0];
      // signature set wins over read clear
      if (err_evt)
        err_sig_ff <= err_code;
      else if (control_status_load_clr |
               (reg_rd_i && reg_addr_i == `PDL_REG_STATUS_B))
        err_sig_ff <= `PDL_ERR_NONE;
    end
  end

  pdl_kmem u_kmem (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .wr_i    (key_we),
    .waddr_i (key_idx_ff[3:0]),
    .wdata_i (rx_data),
    .raddr_i (key_addr_i),
    .rdata_o (key_data_o)
  );

  // clock request withdrawn when off or held
  assign clk_req_o = (state_ff >= S_DRIVE);
  assign pin_oe_o = (state_ff == S_DRIVE) | eng_tx_ff;
  assign pin_o = eng_tx_ff & tx_sh_ff[0];
  assign reg_rdata_o = rdata_ff;
  assign bus_req_o = (state_ff == S_BUS);
  assign ins_byte_o = ins_ff;
  assign ins_opcode_o = ins_ff[7:5];
  assign ins_addr_bytes_o = sz_bytes(ins_ff[3:2]);
  assign ins_data_bytes_o = sz_bytes(ins_ff[1:0]);
  assign key_valid_o = key_valid_ff;
endmodule // pdl_ctrl

// *** tb/pdl_dbg_model.sv ***
/* debugger model on the link pin.
   assumes the pin is pulled up while nobody drives it low */
`timescale 1ns/1ps
module pdl_dbg_model #(parameter int BIT = 256) (
  input  logic clock_i, // bench clock
  input  logic line_i,  // resolved pin level
  output logic low_o    // model pulls the pin low
);
  initial low_o = 1'b0;
  task automatic hold(input bit v, input int n);
    low_o <= !v;
    repeat (n) @(posedge clock_i);
  endtask
  task automatic frame(input [7:0] b, input bit bad);
    hold(0, BIT);
    for (int i = 0; i < 8; i++) hold(b[i], BIT);
    hold(^b ^ bad, BIT);
    hold(1, 2 * BIT);
  endtask
  task automatic recv(output [7:0] b);
    int t;
    for (t = 0; t < 40000 && line_i; t++) @(posedge clock_i);
    repeat (BIT + BIT / 2) @(posedge clock_i);
    for (int i = 0; i < 8; i++) begin
      b[i] = line_i;
      repeat (BIT) @(posedge clock_i);
    end
    // let parity and stop bits pass before the line turns
    repeat (3 * BIT) @(posedge clock_i);
  endtask
endmodule // pdl_dbg_model

// *** tb/pdl_ctrl_sva.sv ***
/* port assertions for pdl_ctrl.
   assumes ce_i held high by the bench */
`timescale 1ns/1ps
module pdl_ctrl_sva (
  input wire       clock_i,            // clock
  input wire       reset_i,            // power-on reset
  input wire       sys_reset_i,        // system reset
  input wire [1:0] reset_pin_config_i, // fuse field
  input wire       hv_pulse_i,         // high voltage
  input wire       pin_o,              // pin value
  input wire       pin_oe_o,           // pin enable
  input wire       pin_is_debug_o,     // pin on link
  input wire       gpio_drive_allow_o, // gpio allowed
  input wire       clk_req_o,          // clock request
  input wire [3:0] reg_addr_i,         // address
  input wire [7:0] reg_wdata_i,        // write data
  input wire       reg_wr_i,           // write strobe
  input wire       reg_rd_i,           // read strobe
  input wire [7:0] reg_rdata_o,        // read data
  input wire       key_valid_o         // keys held
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  a_read_idle:
    assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside its slot");
  a_sig_width:
    assert property (reg_rd_i && reg_addr_i == 4'h1 |=> reg_rdata_o < 8'h08)
    else $error("signature wider than field");
  a_dis_keys:
    assert property (reg_wr_i && reg_addr_i == 4'h3 && reg_wdata_i[2]
      |-> ##[1:4] !clk_req_o && !key_valid_o)
    else $error("disable kept clock or keys");
  a_hv_enable:
    assert property ($rose(hv_pulse_i) |-> ##[1:5] pin_is_debug_o)
    else $error("high voltage missed");
  a_hv_sticky:
    assert property (pin_is_debug_o && reset_pin_config_i == 2'h0
      && $past(reset_pin_config_i, 3) == 2'h0 |=> pin_is_debug_o)
    else $error("pin left the link");
  a_gpio_hold:
    assert property (sys_reset_i |=> !gpio_drive_allow_o [*8])
    else $error("gpio allowed too soon");
  a_gpio_fuse:
    assert property (reset_pin_config_i != 2'h0
      && $past(reset_pin_config_i, 2) != 2'h0 |-> !gpio_drive_allow_o)
    else $error("gpio allowed on link pin");
  a_tx_start:
    assert property ($rose(pin_oe_o) |-> !pin_o)
    else $error("drive began high");
endmodule // pdl_ctrl_sva
bind pdl_ctrl pdl_ctrl_sva u_sva (.clock_i, .reset_i, .sys_reset_i,
  .reset_pin_config_i, .hv_pulse_i, .pin_o, .pin_oe_o, .pin_is_debug_o,
  .gpio_drive_allow_o, .clk_req_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .key_valid_o);

// *** tb/pdl_ctrl_tb_top.sv ***
/* bench for pdl_ctrl: register port, fuse, high voltage, slow clock.
   assumes the link pin has a pull-up */
`timescale 1ns/1ps
module pdl_ctrl_tb_top;
  localparam int BIT = 256;
  logic       clock_i, reset_i, sys_reset_i, hv_pulse_i, lso_clk_i;
  logic       bus_ack_i, reg_wr_i, reg_rd_i, rd_d;
  logic [1:0] reset_pin_config_i;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i, rx, g;
  logic [7:0] expq[$];
  wire  [7:0] reg_rdata_o;
  wire        pin_o, pin_oe_o, low, bus_req_o, clk_req_o;
  wire        pin_is_debug_o, gpio_o;
  wire        line = pin_oe_o ? pin_o : !low;
  int         err_count, comparisons;
  pdl_ctrl #(.SYNC_TMO_CYC(19'd2000)) u_dut (.clock_i, .reset_i,
    .ce_i(1'b1), .sys_reset_i, .reset_pin_config_i, .hv_pulse_i,
    .lso_clk_i, .pin_i(line), .pin_o, .pin_oe_o, .pin_is_debug_o,
    .gpio_drive_allow_o(gpio_o), .clk_req_o, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .bus_req_o, .bus_ack_i,
    .ins_byte_o(), .ins_opcode_o(), .ins_addr_bytes_o(),
    .ins_data_bytes_o(), .key_valid_o(), .key_addr_i(4'h0),
    .key_data_o());
  pdl_dbg_model #(.BIT(BIT)) u_dbg (.clock_i, .line_i(line), .low_o(low));
  initial begin
    clock_i = 0;
    forever #20 clock_i = ~clock_i;
  end
  initial begin
    lso_clk_i = 0;
    forever #80 lso_clk_i = ~lso_clk_i;
  end
  task automatic chk(input [7:0] e, input [7:0] v);
    comparisons++;
    if (v !== e) begin
      err_count++;
      $display("ERROR %0t exp %h got %h", $time, e, v);
    end
  endtask
  always @(posedge clock_i) begin
    bus_ack_i <= bus_req_o;
    rd_d <= reg_rd_i;
    if (rd_d) chk(expq.pop_front(), reg_rdata_o);
  end
  task automatic wr(input [3:0] a, input [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1;
    @(posedge clock_i);
    reg_wr_i <= 0;
  endtask
  task automatic rd(input [3:0] a, input [7:0] e);
    expq.push_back(e);
    reg_addr_i <= a;
    reg_rd_i <= 1;
    @(posedge clock_i);
    reg_rd_i <= 0;
    @(posedge clock_i);
  endtask
  task automatic control_status_load(input [3:0] a, input [7:0] e);
    u_dbg.frame(8'h55, 0);
    u_dbg.frame({4'h8, a}, 0);
    u_dbg.recv(rx);
    chk(e, rx);
  endtask
  task automatic enable();
    u_dbg.hold(0, 8);
    u_dbg.hold(1, 2 * BIT);
  endtask
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clock_i);
    err_count++;
    test_done();
  end
  initial begin
    {reset_i, sys_reset_i, hv_pulse_i, reg_wr_i, reg_rd_i} = 5'h10;
    {reset_pin_config_i, reg_addr_i, reg_wdata_i} = 14'h0000;
    {bus_ack_i, rd_d, err_count, comparisons} = 0;
    void'($urandom(65));
    repeat (12) @(posedge clock_i);
    reset_i <= 0;
    repeat (2000) @(posedge clock_i);
    chk(8'h00, 8'(gpio_o));
    repeat (1400) @(posedge clock_i);
    chk(8'h01, 8'(gpio_o));
    reset_pin_config_i <= 2'h1;
    repeat (4) @(posedge clock_i);
    chk(8'h00, 8'(gpio_o));
    reset_pin_config_i <= 2'h0;
    sys_reset_i <= 1;
    @(posedge clock_i);
    sys_reset_i <= 0;
    repeat (20) @(posedge clock_i);
    chk(8'h00, 8'(gpio_o));
    $display("test gpio protection done");
    hv_pulse_i <= 1;
    repeat (2500) @(posedge clock_i);
    hv_pulse_i <= 0;
    g = 8'($urandom_range(6, 4));
    wr(4'h2, g);
    enable();
    control_status_load(4'h1, 8'h00);
    rd(4'h2, g);
    control_status_load(4'h2, g);
    rd(4'h5, 8'h00);
    $display("test link load done");
    wr(4'h9, 8'h02);
    u_dbg.frame(8'h55, 0);
    u_dbg.frame(8'h81, 1);
    u_dbg.hold(0, 14 * BIT);
    u_dbg.hold(1, 2 * BIT);
    rd(4'h9, 8'h03);
    control_status_load(4'h1, 8'h01);
    rd(4'h1, 8'h00);
    $display("test error recovery done");
    wr(4'h3, 8'h04);
    repeat (4) @(posedge clock_i);
    chk(8'h00, 8'(clk_req_o));
    chk(8'h01, 8'(pin_is_debug_o));
    enable();
    chk(8'h01, 8'(clk_req_o));
    repeat (1700) @(posedge clock_i);
    chk(8'h00, 8'(clk_req_o));
    $display("test disable done");
    test_done();
  end
endmodule // pdl_ctrl_tb_top
